// ===== rtl/pic_defs.svh
// Offsets, field positions, reset values and vector codes of the
// interrupt controller. Included by the package and the controller.
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_OFF_CSR        12'h000
`define PIC_OFF_ENABLE     12'h010
`define PIC_OFF_KIND       12'h014
`define PIC_OFF_PSET       12'h018
`define PIC_OFF_PCLR       12'h01C
`define PIC_OFF_PRIO_LO    12'h040
`define PIC_OFF_PRIO_HI    12'h05C
`define PIC_OFF_SYS        12'h060

`define PIC_CSR_SOFT_RESET_BIT_BIT   31
`define PIC_CSR_SET_BIT    28
`define PIC_CSR_CAN_BIT    27
`define PIC_SYS_TMR_MSB    7
`define PIC_SYS_TRAP_MSB   15
`define PIC_PRIO_MSB       7

`define PIC_RST_WORD       32'h0000_0000
`define PIC_RST_VEC        7'h00
`define PIC_NO_PRIO        9'h100
`define PIC_PRI_STEP       6

`define PIC_VEC_TIMER      7'h0F
`define PIC_VEC_TRAP       7'h0E
`define PIC_VEC_SRC_BASE   7'h20

`endif

// ===== rtl/pic_pkg.sv
// Types shared by the interrupt controller and its bench.
// Assumes pic_defs.svh is on the include path.
`include "pic_defs.svh"

package pic_pkg;
  typedef logic [8:0] pic_prio_t;
  typedef logic [6:0] pic_vec_t;
  typedef enum logic [1:0]
  {
    PIC_INACTIVE = 2'b00,
    PIC_PENDING  = 2'b01,
    PIC_ACTIVE   = 2'b10,
    PIC_PEND_ACT = 2'b11
  } pic_state_t;
endpackage

// ===== rtl/pic_ctrl.sv
// Prioritised interrupt controller with an APB register slave.
// Assumes a CPU that pulses irq_ack to take the presented vector and
// pulses irq_return with return_vector when a service routine ends.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "pic_defs.svh"

module pic_ctrl
  import pic_pkg::*;
#(
  parameter int NSRC = 32
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NSRC-1:0] src_irq,
  input  wire logic            timer_irq,
  output logic                 irq_req,
  output pic_vec_t             irq_vector,
  input  wire logic            irq_ack,
  input  wire logic            irq_return,
  input  wire pic_vec_t        return_vector,
  output logic                 system_reset_request
);

  // Entry 0 is the timer, entry 1 the software trap, 2.. the sources
  localparam int NE = NSRC + 2;

  logic [NSRC-1:0] level_enable;
  logic [NSRC-1:0] pulse_select;
  logic [1:0]      src_off [NSRC];
  logic [1:0]      timer_priority_offset;
  logic [1:0]      trap_priority_offset;
  pic_vec_t        vector_number;
  logic [NE-1:0]   pend;
  logic [NE-1:0]   act;
  logic [NE-1:0]   prev_in;
  logic [5:0]      sel_idx;

  logic [NE-1:0]   in_all;
  logic [NE-1:0]   pulse_all;
  logic [NE-1:0]   en_all;
  logic [NE-1:0]   ret_hit;
  logic [NE-1:0]   set_p;
  logic [NE-1:0]   clr_p;
  logic [NE-1:0]   ent_hit;
  pic_prio_t       best_pri;
  pic_prio_t       run_pri;
  logic [5:0]      best_idx;
  logic            next_req;

  logic            wr;
  logic            rd_setup;
  logic            hit_csr;
  logic            hit_en;
  logic            hit_kind;
  logic            hit_pset;
  logic            hit_pclr;
  logic            hit_prio;
  logic            hit_sys;
  logic            hit_any;
  logic            trap_set_wr;
  logic            trap_can_wr;
  logic            enter;
  logic [31:0]     next_rdata;

  assign in_all    = {src_irq, 1'b0, timer_irq};
  // Trap is software-only, so its kind bit keeps level logic off it
  assign pulse_all = {pulse_select, 2'b10};
  assign en_all    = {level_enable, 2'b11};
  assign enter     = irq_ack && irq_req;

  function automatic pic_vec_t idx_to_vec(input logic [5:0] idx);
    if (idx == 6'h00)
      return `PIC_VEC_TIMER;
    else if (idx == 6'h01)
      return `PIC_VEC_TRAP;
    else
      return `PIC_VEC_SRC_BASE + 7'(idx - 6'h02);
  endfunction

  function automatic logic [1:0] off_of(input int i);
    if (i == 0)
      return timer_priority_offset;
    else if (i == 1)
      return trap_priority_offset;
    else
      return src_off[i-2];
  endfunction

  // APB decode; zero wait states, data is loaded in the setup cycle
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit_csr  = paddr == `PIC_OFF_CSR;
  assign hit_en   = paddr == `PIC_OFF_ENABLE;
  assign hit_kind = paddr == `PIC_OFF_KIND;
  assign hit_pset = paddr == `PIC_OFF_PSET;
  assign hit_pclr = paddr == `PIC_OFF_PCLR;
  assign hit_prio = paddr >= `PIC_OFF_PRIO_LO
                    && paddr <= `PIC_OFF_PRIO_HI
                    && paddr[1:0] == 2'b00;
  assign hit_sys  = paddr == `PIC_OFF_SYS;
  assign hit_any  = hit_csr || hit_en || hit_kind || hit_pset
                    || hit_pclr || hit_prio || hit_sys;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit_any;

  assign trap_set_wr = wr && hit_csr && pwdata[`PIC_CSR_SET_BIT];
  assign trap_can_wr = wr && hit_csr && pwdata[`PIC_CSR_CAN_BIT];

  // Effective priority is the offset times 64 plus the entry index; lower wins
  always_comb
  begin
    pic_prio_t eff;
    eff      = '0;
    best_pri = `PIC_NO_PRIO;
    run_pri  = `PIC_NO_PRIO;
    best_idx = '0;
    for (int i = 0; i < NE; i++)
    begin
      eff = {1'b0, off_of(i), 6'h00} + 9'(i);
      if (pend[i] && en_all[i] && eff < best_pri)
      begin
        best_pri = eff;
        best_idx = 6'(i);
      end
      if (act[i] && eff < run_pri)
        run_pri = eff;
    end
  end

  // Only a strictly better priority interrupts the running service
  assign next_req = best_pri < run_pri;

  always_comb
  begin
    for (int i = 0; i < NE; i++)
    begin
      ret_hit[i] = irq_return && return_vector == idx_to_vec(6'(i));
      ent_hit[i] = enter && sel_idx == 6'(i);
    end
  end

  always_comb
  begin
    for (int i = 0; i < NE; i++)
    begin
      // Level set is masked on entry, else the source would re-enter
      if (i == 1)
        set_p[i] = trap_set_wr;
      else if (pulse_all[i])
        set_p[i] = in_all[i] && !prev_in[i];
      else
        set_p[i] = in_all[i] && (!act[i] || ret_hit[i])
                   && !ent_hit[i];
      clr_p[i] = ent_hit[i];
      if (i == 1)
        clr_p[i] = ent_hit[i] || trap_can_wr;
    end
    if (wr && hit_pset)
      set_p[NE-1:2] = set_p[NE-1:2] | pwdata[NSRC-1:0];
    if (wr && hit_pclr)
      clr_p[NE-1:2] = clr_p[NE-1:2] | pwdata[NSRC-1:0];
  end

  // A set arriving with a clear wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend    <= '0;
      act     <= '0;
      prev_in <= '0;
    end
    else
    begin
      pend    <= (pend & ~clr_p) | set_p;
      act     <= (act & ~ret_hit) | ent_hit;
      prev_in <= in_all;
    end
  end

  // The request drops at entry so a stale vector is never re-taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req    <= 1'b0;
      irq_vector <= `PIC_RST_VEC;
      sel_idx    <= '0;
    end
    else
    begin
      irq_req    <= next_req && !enter;
      irq_vector <= idx_to_vec(best_idx);
      sel_idx    <= best_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_number <= `PIC_RST_VEC;
    else if (enter)
      vector_number <= irq_vector;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      system_reset_request <= 1'b0;
    else
      system_reset_request <= wr && hit_csr
                              && pwdata[`PIC_CSR_SOFT_RESET_BIT_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_enable          <= `PIC_RST_WORD;
      pulse_select          <= `PIC_RST_WORD;
      timer_priority_offset <= 2'b00;
      trap_priority_offset  <= 2'b00;
    end
    else if (wr && hit_en)
      level_enable <= pwdata[NSRC-1:0];
    else if (wr && hit_kind)
      pulse_select <= pwdata[NSRC-1:0];
    else if (wr && hit_sys)
    begin
      if (pstrb[0])
        timer_priority_offset <=
          pwdata[`PIC_SYS_TMR_MSB -: 2];
      if (pstrb[1])
        trap_priority_offset <=
          pwdata[`PIC_SYS_TRAP_MSB -: 2];
    end
  end

  // Only the select bits of each priority byte are kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NSRC; i++)
        src_off[i] <= 2'b00;
    end
    else if (wr && hit_prio)
    begin
      for (int b = 0; b < 4; b++)
        if (pstrb[b] && (32'(paddr[4:2]) * 4 + b) < NSRC)
          src_off[32'(paddr[4:2]) * 4 + b] <=
            pwdata[b*8 + `PIC_PRIO_MSB -: 2];
    end
  end

  always_comb
  begin
    next_rdata = '0;
    if (hit_csr)
    begin
      next_rdata[`PIC_CSR_SET_BIT] = pend[1];
      next_rdata[`PIC_CSR_CAN_BIT] = pend[1];
      next_rdata[6:0]              = vector_number;
    end
    else if (hit_en)
      next_rdata[NSRC-1:0] = level_enable;
    else if (hit_kind)
      next_rdata[NSRC-1:0] = pulse_select;
    else if (hit_pset || hit_pclr)
      next_rdata[NSRC-1:0] = pend[NE-1:2];
    else if (hit_prio)
    begin
      for (int b = 0; b < 4; b++)
        if ((32'(paddr[4:2]) * 4 + b) < NSRC)
          next_rdata[b*8 + `PIC_PRIO_MSB -: 2] =
            src_off[32'(paddr[4:2]) * 4 + b];
    end
    else if (hit_sys)
    begin
      next_rdata[`PIC_SYS_TMR_MSB -: 2]  = timer_priority_offset;
      next_rdata[`PIC_SYS_TRAP_MSB -: 2] = trap_priority_offset;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `PIC_RST_WORD;
    else if (rd_setup)
      prdata <= next_rdata;
  end

  reset_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    system_reset_request |=> !system_reset_request)
    else $error("reset request longer than one cycle");

  soft_reset_bit_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && hit_csr |=> !prdata[`PIC_CSR_SOFT_RESET_BIT_BIT])
    else $error("soft reset bit read as one");

  trap_entry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    enter && sel_idx == 6'h01 && !trap_set_wr |=> !pend[1] && act[1])
    else $error("trap not moved to active on entry");

  preempt_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(irq_req) |-> $past(best_pri) < $past(run_pri))
    else $error("request raised without better priority");

  vec_latch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    enter |=> vector_number == $past(irq_vector))
    else $error("vector field not loaded at entry");

  enable_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_req && sel_idx > 6'h01
    |-> $past(pend[best_idx] && en_all[best_idx]))
    else $error("disabled source presented");

  pset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_pset && !enter
    |=> (pend[NE-1:2] & $past(pwdata[NSRC-1:0]))
        == $past(pwdata[NSRC-1:0]))
    else $error("pending-set write did not pend");

  level_return_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_return ##0 (|(ret_hit & ~pulse_all & in_all))
    |=> (pend & $past(ret_hit & ~pulse_all & in_all))
        == $past(ret_hit & ~pulse_all & in_all))
    else $error("level source not re-pended on return");

endmodule

// ===== tb/pic_cpu_model.sv
// CPU-side model: takes each presented request, returns on command.
// Drives the one-cycle ack and return pulses that the controller assumes.
`timescale 1ns/1ns
module pic_cpu_model
  import pic_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire logic     take_en,
  input  wire logic     ret_go,
  input  wire logic     irq_req,
  input  wire pic_vec_t irq_vector,
  output logic          irq_ack,
  output logic          irq_return,
  output pic_vec_t      return_vector
);
  pic_vec_t stk [8];
  int       depth;

  // Return vector is junk outside its pulse, so a stale value never helps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ack       <= 1'b0;
      irq_return    <= 1'b0;
      return_vector <= 7'h00;
      depth         <= 0;
    end
    else
    begin
      irq_ack       <= take_en && irq_req && !irq_ack;
      irq_return    <= 1'b0;
      return_vector <= ~return_vector;
      if (irq_ack && irq_req)
      begin
        stk[depth] <= irq_vector;
        depth      <= depth + 1;
      end
      else if (ret_go && depth > 0)
      begin
        irq_return    <= 1'b1;
        return_vector <= stk[depth-1];
        depth         <= depth - 1;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench of the interrupt controller.
// Assumes pic_defs.svh on the include path; a CPU model on the far side.
`timescale 1ns/1ns
`include "pic_defs.svh"
module testbench
  import pic_pkg::*;
;
  typedef struct packed
  {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
  } pic_row_t;
  localparam pic_row_t ROWS [20] = '{
    '{1'b0, `PIC_OFF_CSR, 32'h0}, '{1'b0, `PIC_OFF_ENABLE, 32'h0},
    '{1'b0, `PIC_OFF_PSET, 32'h0}, '{1'b0, `PIC_OFF_SYS, 32'h0},
    '{1'b1, `PIC_OFF_ENABLE, 32'hA5A5_0F0F},
    '{1'b0, `PIC_OFF_ENABLE, 32'hA5A5_0F0F},
    '{1'b1, `PIC_OFF_PSET, 32'h11}, '{1'b0, `PIC_OFF_PSET, 32'h11},
    '{1'b0, `PIC_OFF_PCLR, 32'h11}, '{1'b1, `PIC_OFF_PCLR, 32'h1},
    '{1'b0, `PIC_OFF_PSET, 32'h10}, '{1'b1, `PIC_OFF_PCLR, 32'h10},
    '{1'b1, `PIC_OFF_PRIO_HI, 32'hFFFF_FFFF},
    '{1'b0, `PIC_OFF_PRIO_HI, 32'hC0C0_C0C0},
    '{1'b1, `PIC_OFF_SYS, 32'hC0C0}, '{1'b0, `PIC_OFF_SYS, 32'hC0C0},
    '{1'b1, `PIC_OFF_CSR, 32'h1000_0000},
    '{1'b0, `PIC_OFF_CSR, 32'h1800_0000},
    '{1'b1, `PIC_OFF_CSR, 32'h0800_0000}, '{1'b0, `PIC_OFF_CSR, 32'h0}};
  localparam logic [11:0] RA [5] = '{`PIC_OFF_CSR, `PIC_OFF_ENABLE,
    `PIC_OFF_PSET, `PIC_OFF_PRIO_HI, `PIC_OFF_SYS};
  localparam logic [31:0] SYSW [2] = '{32'h0, 32'h80C0};
  localparam pic_vec_t ORD [2][3] = '{'{7'h0F, 7'h0E, 7'h20},
    '{7'h20, 7'h0E, 7'h0F}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] src_irq = 32'h0;
  logic        timer_irq = 1'b0;
  logic        take_en = 1'b0;
  logic        ret_go = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, irq_req, irq_ack, irq_return;
  logic        system_reset_request;
  pic_vec_t    irq_vector, return_vector;
  pic_vec_t    seen [$];
  int          n_errors = 0, check_count = 0, nxt = 0, n_rst = 0;

  always #10 pclk = ~pclk;

  pic_ctrl pic_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_irq(src_irq), .timer_irq(timer_irq), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return),
    .return_vector(return_vector),
    .system_reset_request(system_reset_request));
  pic_cpu_model pic_cpu_model_inst (.pclk(pclk), .presetn(presetn),
    .take_en(take_en), .ret_go(ret_go), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return),
    .return_vector(return_vector));

  always @(posedge pclk)
  begin
    if (irq_ack === 1'b1 && irq_req === 1'b1)
      seen.push_back(irq_vector);
    if (system_reset_request === 1'b1)
      n_rst++;
  end

  task results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task pulse(input logic [31:0] m);
    @(posedge pclk);
    src_irq <= m;
    @(posedge pclk);
    src_irq <= 32'h0;
  endtask

  task took(input pic_vec_t v);
    repeat (40)
      if (seen.size() <= nxt)
        @(posedge pclk);
    chk("vector", 32'(v), 32'(seen.size() > nxt ? seen[nxt] : 7'h7F));
    nxt++;
  endtask

  task quiet();
    repeat (10) @(posedge pclk);
    chk("entries", 32'(nxt), 32'(seen.size()));
  endtask

  task ret();
    @(posedge pclk);
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i])
    begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w)
        chk("table", ROWS[i].d, rd);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    apb(1'b1, `PIC_OFF_CSR, 32'h1000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RA[i])
      rc("reset", RA[i], 32'h0);
    n_rst = 0;
    apb(1'b1, `PIC_OFF_CSR, 32'h8000_0000);
    repeat (4) @(posedge pclk);
    chk("soft_reset_bit", 32'h1, 32'(n_rst));
    rc("csr", `PIC_OFF_CSR, 32'h0);
    apb(1'b1, `PIC_OFF_ENABLE, 32'hFFFF_FFFF);
    take_en <= 1'b1;
    src_irq <= 32'h8;
    took(7'h23);
    rc("csr", `PIC_OFF_CSR, 32'h23);
    rc("pend", `PIC_OFF_PSET, 32'h0);
    ret();
    took(7'h23);
    src_irq <= 32'h0;
    ret();
    quiet();
    apb(1'b1, `PIC_OFF_ENABLE, 32'h0);
    src_irq <= 32'h80;
    quiet();
    rc("pend", `PIC_OFF_PSET, 32'h80);
    apb(1'b1, `PIC_OFF_ENABLE, 32'hFFFF_FFFF);
    took(7'h27);
    src_irq <= 32'h0;
    ret();
    // Pulse mode from here, so level re-pending cannot mask ordering
    apb(1'b1, `PIC_OFF_KIND, 32'hFFFF_FFFF);
    rc("kind", `PIC_OFF_KIND, 32'hFFFF_FFFF);
    apb(1'b1, `PIC_OFF_PRIO_LO, 32'h0040_0000);
    take_en <= 1'b0;
    pulse(32'h24);
    take_en <= 1'b1;
    took(7'h25);
    quiet();
    ret();
    took(7'h22);
    ret();
    pulse(32'h10);
    took(7'h24);
    pulse(32'h2);
    took(7'h21);
    pulse(32'h200);
    quiet();
    ret();
    quiet();
    ret();
    took(7'h29);
    ret();
    pulse(32'h10);
    took(7'h24);
    pulse(32'h10);
    quiet();
    ret();
    took(7'h24);
    ret();
    quiet();
    for (int c = 0; c < 2; c++)
    begin
      take_en <= 1'b0;
      apb(1'b1, `PIC_OFF_SYS, SYSW[c]);
      apb(1'b1, `PIC_OFF_CSR, 32'h1000_0000);
      timer_irq <= 1'b1;
      pulse(32'h1);
      take_en <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
        took(ORD[c][k]);
        if (ORD[c][k] == 7'h0F)
          timer_irq <= 1'b0;
        quiet();
        ret();
      end
      rc("csr", `PIC_OFF_CSR, 32'(ORD[c][2]));
    end
    results();
  end
endmodule
